/* clkd_defines.svh */
// register offsets, field positions and reset values of the clock control
`ifndef CLKD_DEFINES_SVH
`define CLKD_DEFINES_SVH

`define CLKD_NUM_BANKS 5
`define CLKD_ADDR_W 12

`define CLKD_CONFIG_OFS 12'h000
`define CLKD_STATUS_OFS 12'h004

`define CLKD_CFG_BANK_DIS_LSB 0
`define CLKD_CFG_PLL_DIS 5
`define CLKD_CFG_STOP_LEVEL 6
`define CLKD_CFG_STOP_GATED 7
`define CLKD_CFG_W 8
`define CLKD_CFG_RESET 8'h00

`define CLKD_ST_LOCK 0
`define CLKD_ST_PLL_ACTIVE 1
`define CLKD_ST_BYPASS 2
`define CLKD_ST_POWER_DOWN 3
`define CLKD_ST_GATED 4
`define CLKD_ST_STOP_LEVEL 5
`define CLKD_ST_JTAG_SEL 6
`define CLKD_ST_BANK_EN_LSB 8

`define CLKD_RDATA_RESET 32'h0000_0000

`endif

/* clkd_pkg.sv */
// types shared by the clock control modules
package clkd_pkg;

   // output state of one bank; gray coded along run -> stopped
   typedef enum logic [1:0] {
      CLKD_BANK_RUN = 2'b00,
      CLKD_BANK_STOPPING = 2'b01,
      CLKD_BANK_STOPPED = 2'b11
   } clkd_bank_state_t;

   typedef enum logic [1:0] {
      CLKD_STOP_TRISTATE = 2'b00,
      CLKD_STOP_GATED_HIGH = 2'b01,
      CLKD_STOP_GATED_LOW = 2'b11
   } clkd_stop_kind_t;

endpackage

/* clkd_apb_regs.sv */
// apb slave holding the configuration bits and reading back status
`timescale 1ns/10ps
`include "clkd_defines.svh"
module clkd_apb_regs
   import clkd_pkg::*;
#(
   parameter int ADDR_W = `CLKD_ADDR_W,
   parameter int CFG_W = `CLKD_CFG_W
) (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [ADDR_W-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   input wire logic [31:0] status_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output logic [CFG_W-1:0] config_out
);

   logic access;
   logic hit_config;
   logic hit_status;

   assign access = psel_in & penable_in;
   assign hit_config = (paddr_in == `CLKD_CONFIG_OFS);
   assign hit_status = (paddr_in == `CLKD_STATUS_OFS);
   // zero wait states: every access completes on its first access cycle
   assign pready_out = 1'b1;
   assign pslverr_out = access & ~(hit_config | hit_status);

   // =============================================
   // configuration register
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         config_out <= `CLKD_CFG_RESET;
      end else if (access && pwrite_in && hit_config && pstrb_in[0]) begin
         config_out <= pwdata_in[CFG_W-1:0];
      end
   end

   // =============================================
   // read data decode
   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = `CLKD_RDATA_RESET;
      if (hit_config) begin
         next_rdata[CFG_W-1:0] = config_out;
      end else if (hit_status) begin
         next_rdata = status_in;
      end
   end

   // combinational read keeps the zero-wait answer honest
   assign prdata_out = (access && !pwrite_in) ? next_rdata
                                              : `CLKD_RDATA_RESET;

endmodule

/* clkd_bank_gate.sv */
// one output bank: synchronous stop and choice of stopped state
`timescale 1ns/10ps
`include "clkd_defines.svh"
module clkd_bank_gate
   import clkd_pkg::*;
#(
   parameter int WIDTH = 2
) (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire logic clk_src_in,
   input wire logic stop_req_in,
   input wire logic force_stop_in,
   input wire clkd_stop_kind_t stop_kind_in,
   output logic [WIDTH-1:0] q_out,
   output logic [WIDTH-1:0] q_oe_out,
   output logic enabled_out
);

   clkd_bank_state_t state;
   clkd_bank_state_t next_state;

   // stop on request and restart only while the source is low so no runt pulse leaves; force_stop_in stops at any source level
   always_comb begin
      next_state = state;
      unique case (state)
         CLKD_BANK_RUN: begin
            if (stop_req_in) begin
               next_state = CLKD_BANK_STOPPING;
            end
         end
         CLKD_BANK_STOPPING: begin
            if (!stop_req_in) begin
               next_state = CLKD_BANK_RUN;
            end else if (!clk_src_in) begin
               next_state = CLKD_BANK_STOPPED;
            end
         end
         CLKD_BANK_STOPPED: begin
            if (!stop_req_in && !clk_src_in) begin
               next_state = CLKD_BANK_RUN;
            end
         end
         default: begin
            next_state = CLKD_BANK_STOPPED;
         end
      endcase
      if (force_stop_in) begin
         next_state = CLKD_BANK_STOPPED;
      end
   end

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state <= CLKD_BANK_STOPPED;
      end else begin
         state <= next_state;
      end
   end

   // output data and enables from flip-flops
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         q_out <= '0;
         q_oe_out <= '0;
      end else if (next_state != CLKD_BANK_STOPPED) begin
         q_out <= {WIDTH{clk_src_in}};
         q_oe_out <= '1;
      end else begin
         unique case (stop_kind_in)
            CLKD_STOP_GATED_HIGH: begin
               q_out <= '1;
               q_oe_out <= '1;
            end
            CLKD_STOP_GATED_LOW: begin
               q_out <= '0;
               q_oe_out <= '1;
            end
            CLKD_STOP_TRISTATE: begin
               q_out <= '0;
               q_oe_out <= '0;
            end
            default: begin
               q_out <= '0;
               q_oe_out <= '0;
            end
         endcase
      end
   end

   assign enabled_out = (state == CLKD_BANK_RUN);

endmodule

/* clkd_top.sv */
// output, bypass, power-down, lock and programming-port control
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/10ps
`include "clkd_defines.svh"
module clkd_top
   import clkd_pkg::*;
#(
   parameter int NUM_BANKS = `CLKD_NUM_BANKS,
   parameter int ADDR_W = `CLKD_ADDR_W
) (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   // apb register port
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [ADDR_W-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // control pins
   input wire logic pll_bypass_in,
   input wire logic power_down_n_in,
   input wire logic stop_mode_select_in,
   input wire logic [NUM_BANKS-1:0] bank_output_disable_in,
   input wire logic ref_select_in,
   input wire logic [1:0] ref_clk_in,
   // from the analog loop
   input wire logic pll_clk_in,
   input wire logic pll_locked_in,
   // programming port selection
   input wire logic test_reset_n_in,
   input wire logic interface_select_in,
   // clock outputs
   output logic [2*NUM_BANKS-1:0] bank_outputs_out,
   output logic [2*NUM_BANKS-1:0] bank_outputs_oe_out,
   output logic feedback_output_out,
   output logic feedback_output_n_out,
   output logic feedback_oe_out,
   // status and loop control
   output logic lock_out,
   output logic pll_enable_out,
   output logic input_enable_out,
   output logic jtag_select_out,
   output logic i2c_select_out,
   output logic tap_reset_n_out
);

   logic [`CLKD_CFG_W-1:0] config_bits;
   logic [31:0] status_word;
   logic pll_active;
   logic bypass;
   logic powered_down;
   logic gated;
   logic stop_level;
   logic ref_sel_clk;
   logic clk_src;
   logic [NUM_BANKS-1:0] bank_stop_req;
   logic [NUM_BANKS-1:0] bank_enabled;
   logic fb_enabled;
   logic [1:0] fb_q;
   logic [1:0] fb_oe;
   clkd_stop_kind_t bank_kind;
   clkd_stop_kind_t fb_kind;

   // =============================================
   // register bus
   clkd_apb_regs #(
      .ADDR_W(ADDR_W),
      .CFG_W(`CLKD_CFG_W)
   ) u_regs (
      .mclk_in(mclk_in),
      .reset_n_in(reset_n_in),
      .psel_in(psel_in),
      .penable_in(penable_in),
      .pwrite_in(pwrite_in),
      .paddr_in(paddr_in),
      .pwdata_in(pwdata_in),
      .pstrb_in(pstrb_in),
      .status_in(status_word),
      .prdata_out(prdata_out),
      .pready_out(pready_out),
      .pslverr_out(pslverr_out),
      .config_out(config_bits)
   );

   // =============================================
   // loop and power control
   assign pll_active = ~pll_bypass_in & ~config_bits[`CLKD_CFG_PLL_DIS];
   assign bypass = ~pll_active;
   assign powered_down = ~power_down_n_in;

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pll_enable_out <= 1'b0;
         input_enable_out <= 1'b0;
      end else begin
         pll_enable_out <= pll_active & ~powered_down;
         input_enable_out <= ~powered_down;
      end
   end

   // =============================================
   // clock source: loop output, or the selected reference in bypass
   assign ref_sel_clk = ref_select_in ? ref_clk_in[1] : ref_clk_in[0];
   // inputs are off in power-down so nothing switches inside
   assign clk_src = powered_down ? 1'b0
                  : (bypass ? ref_sel_clk : pll_clk_in);

   // =============================================
   // stop mode
   assign gated = stop_mode_select_in
                | config_bits[`CLKD_CFG_STOP_GATED];
   assign stop_level = config_bits[`CLKD_CFG_STOP_LEVEL];

   always_comb begin
      if (!gated) begin
         bank_kind = CLKD_STOP_TRISTATE;
         fb_kind = CLKD_STOP_TRISTATE;
      end else if (!stop_level) begin
         bank_kind = CLKD_STOP_GATED_HIGH;
         fb_kind = CLKD_STOP_GATED_HIGH;
      end else begin
         bank_kind = CLKD_STOP_GATED_LOW;
         fb_kind = CLKD_STOP_GATED_LOW;
      end
   end

   // =============================================
   // output banks
   genvar b;
   generate
      for (b = 0; b < NUM_BANKS; b = b + 1) begin : g_bank
         assign bank_stop_req[b] = bank_output_disable_in[b]
            | config_bits[`CLKD_CFG_BANK_DIS_LSB + b];
         clkd_bank_gate #(
            .WIDTH(2)
         ) u_bank (
            .mclk_in(mclk_in),
            .reset_n_in(reset_n_in),
            .clk_src_in(clk_src),
            .stop_req_in(bank_stop_req[b]),
            .force_stop_in(powered_down),
            .stop_kind_in(bank_kind),
            .q_out(bank_outputs_out[2*b+1:2*b]),
            .q_oe_out(bank_outputs_oe_out[2*b+1:2*b]),
            .enabled_out(bank_enabled[b])
         );
      end
   endgenerate

   // =============================================
   // feedback pair: the loop needs it, so only power-down stops it
   clkd_bank_gate #(
      .WIDTH(2)
   ) u_feedback (
      .mclk_in(mclk_in),
      .reset_n_in(reset_n_in),
      .clk_src_in(clk_src),
      .stop_req_in(powered_down),
      .force_stop_in(powered_down),
      .stop_kind_in(fb_kind),
      .q_out(fb_q),
      .q_oe_out(fb_oe),
      .enabled_out(fb_enabled)
   );

   assign feedback_output_out = fb_q[0];
   // complement is the inverse of the true output while driven; low, like the true output, when stopped tristate
   assign feedback_output_n_out = fb_oe[1] ? ~fb_q[1] : 1'b0;
   assign feedback_oe_out = fb_oe[0];

   // =============================================
   // lock indication
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         lock_out <= 1'b0;
      end else begin
         lock_out <= pll_locked_in & pll_active & ~powered_down;
      end
   end

   // =============================================
   // programming port selection; the tap reset is combinational
   // on purpose so that it acts without any clock
   assign jtag_select_out = interface_select_in;
   assign i2c_select_out = ~interface_select_in;
   assign tap_reset_n_out = test_reset_n_in & interface_select_in;

   // =============================================
   // status word
   always_comb begin
      status_word = `CLKD_RDATA_RESET;
      status_word[`CLKD_ST_LOCK] = lock_out;
      status_word[`CLKD_ST_PLL_ACTIVE] = pll_active;
      status_word[`CLKD_ST_BYPASS] = bypass;
      status_word[`CLKD_ST_POWER_DOWN] = powered_down;
      status_word[`CLKD_ST_GATED] = gated;
      status_word[`CLKD_ST_STOP_LEVEL] = stop_level;
      status_word[`CLKD_ST_JTAG_SEL] = interface_select_in;
      status_word[`CLKD_ST_BANK_EN_LSB +: NUM_BANKS] = bank_enabled;
   end

endmodule

/* clkd_top_asserts.sv */
// concurrent checks on the clock control top ports
`timescale 1ns/10ps
module clkd_top_asserts #(
   parameter int NUM_BANKS = 5
) (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire logic pll_bypass_in,
   input wire logic pll_locked_in,
   input wire logic power_down_n_in,
   input wire logic stop_mode_select_in,
   input wire logic test_reset_n_in,
   input wire logic interface_select_in,
   input wire logic [2*NUM_BANKS-1:0] bank_outputs_out,
   input wire logic [2*NUM_BANKS-1:0] bank_outputs_oe_out,
   input wire logic feedback_output_out,
   input wire logic feedback_output_n_out,
   input wire logic feedback_oe_out,
   input wire logic lock_out,
   input wire logic pll_enable_out,
   input wire logic input_enable_out,
   input wire logic jtag_select_out,
   input wire logic i2c_select_out,
   input wire logic tap_reset_n_out
);
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!reset_n_in);
   // ====================================================
   // loop, lock and power-down
   a_bypass_pll_off: assert property ($past(pll_bypass_in) |-> !pll_enable_out)
      else $error("loop enabled in bypass");
   a_lock_bypass: assert property ($past(pll_bypass_in) |-> !lock_out)
      else $error("lock shown in bypass");
   a_lock_follow: assert property (lock_out |-> $past(pll_locked_in))
      else $error("lock without loop lock");
   a_pd_inputs: assert property ($past(reset_n_in)
      |-> input_enable_out == $past(power_down_n_in))
      else $error("input enable wrong");
   a_pd_gated: assert property ($past(reset_n_in)
      && !$past(power_down_n_in) && $past(stop_mode_select_in)
      |-> feedback_oe_out)
      else $error("gated stop not driven");
   // ====================================================
   // programming port
   a_tap_reset: assert property (tap_reset_n_out
      == (test_reset_n_in && interface_select_in))
      else $error("tap reset wrong");
   a_jtag_sel: assert property (jtag_select_out == interface_select_in)
      else $error("jtag select wrong");
   a_i2c_sel: assert property (i2c_select_out == !interface_select_in)
      else $error("i2c select wrong");
   // ====================================================
   // output pairs
   a_fb_pair: assert property (feedback_oe_out
      |-> feedback_output_n_out == !feedback_output_out)
      else $error("feedback pair not complementary");
   for (genvar b = 0; b < NUM_BANKS; b++) begin : g_pair
      a_pair_equal: assert property (
         bank_outputs_out[2*b] == bank_outputs_out[2*b+1] &&
         bank_outputs_oe_out[2*b] == bank_outputs_oe_out[2*b+1])
         else $error("bank pair differs");
   end
   c_lock: cover property (lock_out);
   c_pd_gated: cover property (!power_down_n_in && feedback_oe_out);
   c_tap_held: cover property (!tap_reset_n_out && test_reset_n_in);
endmodule

bind clkd_top clkd_top_asserts #(.NUM_BANKS(NUM_BANKS)) chk_u (
   .mclk_in(mclk_in), .reset_n_in(reset_n_in),
   .pll_bypass_in(pll_bypass_in), .pll_locked_in(pll_locked_in),
   .power_down_n_in(power_down_n_in),
   .stop_mode_select_in(stop_mode_select_in),
   .test_reset_n_in(test_reset_n_in),
   .interface_select_in(interface_select_in),
   .bank_outputs_out(bank_outputs_out),
   .bank_outputs_oe_out(bank_outputs_oe_out),
   .feedback_output_out(feedback_output_out),
   .feedback_output_n_out(feedback_output_n_out),
   .feedback_oe_out(feedback_oe_out), .lock_out(lock_out),
   .pll_enable_out(pll_enable_out), .input_enable_out(input_enable_out),
   .jtag_select_out(jtag_select_out), .i2c_select_out(i2c_select_out),
   .tap_reset_n_out(tap_reset_n_out));

/* clkd_clk_source.sv */
// reference and loop clock source with a simple lock model
`timescale 1ns/10ps
module clkd_clk_source (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire logic run_in,
   input wire logic pll_enable_in,
   output logic [1:0] ref_clk_out,
   output logic pll_clk_out,
   output logic pll_locked_out
);
   logic [2:0] phase;
   logic [2:0] settle;
   // ====================================================
   // clocks stand low while stopped
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         phase <= 3'h0;
      end else if (!run_in) begin
         phase <= 3'h0;
      end else begin
         phase <= phase + 3'h1;
      end
   end
   assign ref_clk_out = phase[2:1];
   assign pll_clk_out = phase[0];
   // lock only after the loop has run a while; lost at once
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         settle <= 3'h0;
      end else if (!pll_enable_in) begin
         settle <= 3'h0;
      end else if (settle != 3'h7) begin
         settle <= settle + 3'h1;
      end
   end
   assign pll_locked_out = (settle == 3'h7);
endmodule

/* tb_top.sv */
// self-checking bench of the clock control top
`timescale 1ns/10ps
`include "clkd_defines.svh"
module tb_top;
   localparam logic [11:0] CFG = `CLKD_CONFIG_OFS;
   localparam logic [11:0] STA = `CLKD_STATUS_OFS;
   logic mclk_in, reset_n_in, psel_in, penable_in, pwrite_in, err, run;
   logic [11:0] paddr_in;
   logic [31:0] pwdata_in, prdata_out, rd;
   logic [3:0] pstrb_in;
   logic pready_out, pslverr_out, pll_bypass_in, power_down_n_in, seen;
   logic stop_mode_select_in, ref_select_in, pll_clk_in, pll_locked_in;
   logic test_reset_n_in, interface_select_in, fb, fb_n, fb_oe, lock;
   logic pll_en, in_en, jsel, isel, tap, prev;
   logic [4:0] bank_output_disable_in;
   logic [4:0] tab [5];
   logic [1:0] ref_clk_in;
   logic [9:0] q, oe;
   int failures = 0;
   int num_checks = 0;
   int cycles = 0;
   clkd_top dut_u (.mclk_in, .reset_n_in, .psel_in, .penable_in,
      .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .prdata_out,
      .pready_out, .pslverr_out, .pll_bypass_in, .power_down_n_in,
      .stop_mode_select_in, .bank_output_disable_in, .ref_select_in,
      .ref_clk_in, .pll_clk_in, .pll_locked_in, .test_reset_n_in,
      .interface_select_in, .bank_outputs_out(q), .bank_outputs_oe_out(oe),
      .feedback_output_out(fb), .feedback_output_n_out(fb_n),
      .feedback_oe_out(fb_oe), .lock_out(lock), .pll_enable_out(pll_en),
      .input_enable_out(in_en), .jtag_select_out(jsel),
      .i2c_select_out(isel), .tap_reset_n_out(tap));
   clkd_clk_source src_u (.mclk_in, .reset_n_in, .run_in(run),
      .pll_enable_in(pll_en), .ref_clk_out(ref_clk_in),
      .pll_clk_out(pll_clk_in), .pll_locked_out(pll_locked_in));
   initial begin
      mclk_in = 1'b0;
      forever #12.5 mclk_in = ~mclk_in;
   end
   always @(posedge mclk_in) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         failures = failures + 1;
         $display("mismatch at %0t: timeout", $time);
         summarize();
      end
   end
   // ====================================================
   // shared tasks
   task automatic summarize();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string m);
      num_checks = num_checks + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic w8(input int n);
      repeat (n) @(posedge mclk_in);
   endtask
   // one apb transfer; waits on pready, the run timeout ends a hang
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s);
      @(posedge mclk_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      pstrb_in <= s;
      @(posedge mclk_in);
      penable_in <= 1'b1;
      do begin
         @(posedge mclk_in);
      end while (pready_out !== 1'b1);
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask
   // ====================================================
   // main sequence
   initial begin
      {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
      {pstrb_in, pll_bypass_in, stop_mode_select_in, ref_select_in} = '0;
      {reset_n_in, bank_output_disable_in, interface_select_in} = '0;
      {power_down_n_in, test_reset_n_in, run} = 3'b111;
      tab = '{5'h13, 5'h15, 5'h0B, 5'h0D, 5'h00};
      w8(5);
      chk(32'({oe, lock, pll_en}), 32'h0, "reset outputs");
      reset_n_in <= 1'b1;
      apb(0, CFG, 0, 0);
      chk(rd, 32'h0, "config reset");
      apb(0, 12'h010, 0, 0);
      chk(32'(err), 32'h1, "unmapped error");
      chk(rd, 32'h0, "unmapped read");
      apb(1, CFG, 32'hA5, 4'h1);
      apb(1, CFG, 32'h00, 4'h0);
      apb(0, CFG, 0, 0);
      chk(rd, 32'hA5, "config strobe");
      apb(1, STA, 32'hFFFF_FFFF, 4'hF);
      chk(32'(err), 32'h0, "status write");
      apb(1, CFG, 32'h00, 4'h1);
      w8(12);
      apb(0, STA, 0, 0);
      chk(32'({lock, pll_en, in_en, rd[1:0]}), 32'h1F, "locked");
      pll_bypass_in <= 1'b1;
      w8(3);
      chk(32'({lock, pll_en}), 32'h0, "bypass pin");
      pll_bypass_in <= 1'b0;
      apb(1, CFG, 32'h20, 4'h1);
      ref_select_in <= 1'b1;
      w8(3);
      apb(0, STA, 0, 0);
      chk(32'({pll_en, rd[2:1]}), 32'h2, "bypass bit");
      // every bank output must repeat the selected reference one edge later
      seen = 1'b0;
      prev = ref_clk_in[1];
      repeat (12) begin
         @(posedge mclk_in);
         if (q !== {10{prev}}) seen = 1'b1;
         prev = ref_clk_in[1];
      end
      chk(32'(seen), 32'h0, "reference reaches outputs");
      run <= 1'b0;
      w8(8);
      chk(32'({q, oe}), 32'h003FF, "stopped reference");
      run <= 1'b1;
      // every stop mode, by bank pin and by power-down
      foreach (tab[i]) begin
         stop_mode_select_in <= tab[i][4];
         apb(1, CFG, 32'({tab[i][3:2], 6'h00}), 4'h1);
         bank_output_disable_in <= 5'h01;
         w8(8);
         chk(32'(q[1:0]), 32'({2{tab[i][1]}}), "stop level");
         chk(32'(oe[1:0]), 32'({2{tab[i][0]}}), "stop drive");
         chk(32'(oe[3:2]), 32'h3, "other bank");
         bank_output_disable_in <= 5'h00;
         w8(8);
         chk(32'(oe[1:0]), 32'h3, "bank restart");
         power_down_n_in <= 1'b0;
         w8(4);
         chk(32'({in_en, lock}), 32'h0, "power down");
         chk(32'({q, oe}), 32'({{10{tab[i][1]}}, {10{tab[i][0]}}}),
            "pd banks");
         chk(32'({fb, fb_n, fb_oe}),
            32'({tab[i][1], tab[i][0] & ~tab[i][1], tab[i][0]}),
            "pd feedback");
         apb(0, STA, 0, 0);
         chk(32'(rd[12:3]), 32'({tab[i][2], tab[i][4] | tab[i][3], 1'b1}),
            "pd status");
         power_down_n_in <= 1'b1;
         w8(4);
      end
      apb(1, CFG, 32'h90, 4'h1);
      w8(8);
      chk(32'({q[9:8], oe[9:8]}), 32'hF, "config bank stop");
      for (int i = 0; i < 4; i++) begin
         interface_select_in <= i[0];
         test_reset_n_in <= i[1];
         w8(1);
         chk(32'({jsel, isel, tap}), 32'({i[0], ~i[0], i[0] & i[1]}),
            "port select");
      end
      reset_n_in <= 1'b0;
      w8(2);
      chk(32'(oe), 32'h0, "second reset");
      reset_n_in <= 1'b1;
      apb(0, CFG, 0, 0);
      chk(rd, 32'h0, "config after reset");
      summarize();
   end
endmodule
